//--- rtl/ibe_consts.vh
/*
  constants for the increment/decrement/jump execution block.
  assumes 14-bit instruction words in the usual mid-range encoding.
*/
`ifndef IBE_CONSTS_VH
`define IBE_CONSTS_VH
`define IBE_INSN_W 14
`define IBE_PC_W 13
`define IBE_DATA_W 8
`define IBE_FADDR_W 7
`define IBE_JUMP_W 11
`define IBE_DEST_BIT 7
`define IBE_PAGE_HI 4
`define IBE_PAGE_LO 3
`define IBE_OPJ_HI 13
`define IBE_OPJ_LO 11
`define IBE_OPF_HI 13
`define IBE_OPF_LO 8
`define IBE_OP_JUMP 3'h5
`define IBE_OP_DEC_FILE 6'h03
`define IBE_OP_INC_FILE 6'h0A
`define IBE_OP_DEC_SKIP 6'h0B
`define IBE_OP_INC_SKIP 6'h0F
`define IBE_ST_EXEC 1'h0
`define IBE_ST_FLUSH 1'h1
`endif

//--- rtl/ibe_alu_step.v
/*
  one-step adder for the file-register operand: adds one or subtracts one.
  assumes a purely combinational use inside the execution block.
*/
`timescale 1ns/1ps
`include "ibe_consts.vh"
module ibe_alu_step #(
  parameter W = 8
) (
  input wire [W-1:0] operand_in,
  input wire down_in,
  output wire [W-1:0] result_out,
  output wire zero_out
);
  // wraps modulo 2^W, so 0xFF+1 and 0x01-1 both yield zero
  assign result_out = down_in ? operand_in - {{(W-1){1'h0}}, 1'h1}
                              : operand_in + {{(W-1){1'h0}}, 1'h1};
  assign zero_out = (result_out == {W{1'h0}});
endmodule

//--- rtl/ibe_exec.v
/*
  execution stage for absolute_jump, decrement_file, increment_file,
  decrement_skip_zero and increment_skip_zero.
  assumes: insn_valid_in marks one instruction per instruction cycle; file_data_in
  is the content of the addressed file register in that same cycle (combinational
  read of addr from insn_in); pc_page_latch_in is the page latch register.
  outputs are registered: results appear the cycle after the instruction is taken.
  during a flush cycle the next instruction is dropped as a no-operation.
*/
// Function
// - absolute_jump loads its 11-bit immediate into program_counter bits 10:0.
// - absolute_jump fills program_counter bits 12:11 from page latch bits 4:3.
// - absolute_jump takes two cycles and leaves status flags alone.
// - decrement_file subtracts one, stores by destination bit, updates zero flag.
// - increment_file adds one, stores by destination bit, updates zero flag.
// - decrement_skip_zero decrements, stores, skips next instruction on zero.
// - increment_skip_zero increments, stores, skips next on wrapped zero.
// - nonzero skip result runs next normally; taken skip costs two cycles.
`timescale 1ns/1ps
`include "ibe_consts.vh"
module ibe_exec #(
  parameter DATA_W = `IBE_DATA_W
) (
  input wire clk_sys_in,
  input wire rstn_in,
  input wire insn_valid_in,
  input wire [`IBE_INSN_W-1:0] insn_in,
  input wire [DATA_W-1:0] file_data_in,
  input wire [DATA_W-1:0] pc_page_latch_in,
  output wire pc_load_out,
  output wire [`IBE_PC_W-1:0] program_counter_out,
  output wire flush_out,
  output wire wreg_we_out,
  output wire [DATA_W-1:0] wreg_data_out,
  output wire file_we_out,
  output wire [`IBE_FADDR_W-1:0] file_addr_out,
  output wire [DATA_W-1:0] file_data_out,
  output wire zero_we_out,
  output wire zero_flag_out,
  output wire busy_out
);
  // slot state: executing, or dropping the word that follows a jump or a taken skip
  localparam [0:0] ST_EXEC = `IBE_ST_EXEC;
  localparam [0:0] ST_FLUSH = `IBE_ST_FLUSH;

  // every _reg below is a flop; its _next is the combinational update
  reg state_reg;
  reg state_next;
  reg pc_load_reg;
  reg pc_load_next;
  reg [`IBE_PC_W-1:0] target_reg;
  reg [`IBE_PC_W-1:0] target_next;
  reg flush_reg;
  reg flush_next;
  reg wreg_we_reg;
  reg wreg_we_next;
  reg [DATA_W-1:0] wreg_data_reg;
  reg [DATA_W-1:0] wreg_data_next;
  reg file_we_reg;
  reg file_we_next;
  reg [`IBE_FADDR_W-1:0] file_addr_reg;
  reg [`IBE_FADDR_W-1:0] file_addr_next;
  reg [DATA_W-1:0] file_data_reg;
  reg [DATA_W-1:0] file_data_next;
  reg zero_we_reg;
  reg zero_we_next;
  reg zero_flag_reg;
  reg zero_flag_next;

  // decode of the word presented in this slot
  wire [2:0] op_jump;
  wire [5:0] op_file;
  wire is_jump;
  wire is_dec_file;
  wire is_inc_file;
  wire is_dec_skip;
  wire is_inc_skip;
  wire is_plain_step;
  wire is_skip_step;
  wire is_step;
  wire step_down;
  wire dest_file;
  wire [`IBE_FADDR_W-1:0] faddr;
  wire [`IBE_JUMP_W-1:0] jump_field;
  wire [`IBE_PAGE_HI-`IBE_PAGE_LO:0] page_bits;
  wire [DATA_W-1:0] step_result;
  wire step_zero;
  wire take;
  wire skip_taken;

  // a dropped slot is the no-operation that replaces the following word
  assign take = insn_valid_in && (state_reg == ST_EXEC);
  assign op_jump = insn_in[`IBE_OPJ_HI:`IBE_OPJ_LO];
  assign op_file = insn_in[`IBE_OPF_HI:`IBE_OPF_LO];
  assign is_jump = (op_jump == `IBE_OP_JUMP);
  assign is_dec_file = (op_file == `IBE_OP_DEC_FILE);
  assign is_inc_file = (op_file == `IBE_OP_INC_FILE);
  assign is_dec_skip = (op_file == `IBE_OP_DEC_SKIP);
  assign is_inc_skip = (op_file == `IBE_OP_INC_SKIP);
  assign is_plain_step = is_dec_file | is_inc_file;
  assign is_skip_step = is_dec_skip | is_inc_skip;
  assign is_step = is_plain_step | is_skip_step;
  assign step_down = is_dec_file | is_dec_skip;
  assign dest_file = insn_in[`IBE_DEST_BIT];
  assign faddr = insn_in[`IBE_FADDR_W-1:0];
  assign jump_field = insn_in[`IBE_JUMP_W-1:0];
  assign page_bits = pc_page_latch_in[`IBE_PAGE_HI:`IBE_PAGE_LO];
  // zero is judged on the wrapped result, so a full register rolling over skips
  assign skip_taken = take && is_skip_step && step_zero;

  ibe_alu_step #(
    .W(DATA_W)
  ) u_step (
    .operand_in(file_data_in),
    .down_in(step_down),
    .result_out(step_result),
    .zero_out(step_zero)
  );

  always @* begin
    state_next = ST_EXEC;
    case (state_reg)
      ST_EXEC: begin
        if (take && is_jump) begin
          state_next = ST_FLUSH;
        end else if (skip_taken) begin
          state_next = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        // stalls hold the drop until a real slot arrives, so no word slips past it
        if (insn_valid_in) begin
          state_next = ST_EXEC;
        end else begin
          state_next = ST_FLUSH;
        end
      end
      default: begin
        // unreachable with one state bit, kept as a safe way back
        state_next = ST_EXEC;
      end
    endcase
  end

  always @* begin
    // strobes default low; held values keep their last update
    pc_load_next = 1'h0;
    flush_next = 1'h0;
    wreg_we_next = 1'h0;
    file_we_next = 1'h0;
    zero_we_next = 1'h0;
    target_next = target_reg;
    wreg_data_next = wreg_data_reg;
    file_addr_next = file_addr_reg;
    file_data_next = file_data_reg;
    zero_flag_next = zero_flag_reg;
    if (take && is_jump) begin
      pc_load_next = 1'h1;
      flush_next = 1'h1;
      target_next = {page_bits, jump_field};
    end
    if (take && is_step) begin
      // both data ports take the result; only the selected strobe fires
      wreg_we_next = !dest_file;
      file_we_next = dest_file;
      wreg_data_next = step_result;
      file_data_next = step_result;
      file_addr_next = faddr;
      flush_next = skip_taken;
    end
    // skip forms leave the zero flag strobe low and its value held
    if (take && is_plain_step) begin
      zero_we_next = 1'h1;
      zero_flag_next = step_zero;
    end
  end

  // one cycle of latency: results land on the edge after the word is taken
  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state_reg <= ST_EXEC;
      pc_load_reg <= 1'h0;
      target_reg <= {`IBE_PC_W{1'h0}};
      flush_reg <= 1'h0;
      wreg_we_reg <= 1'h0;
      wreg_data_reg <= {DATA_W{1'h0}};
      file_we_reg <= 1'h0;
      file_addr_reg <= {`IBE_FADDR_W{1'h0}};
      file_data_reg <= {DATA_W{1'h0}};
      zero_we_reg <= 1'h0;
      zero_flag_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      pc_load_reg <= pc_load_next;
      target_reg <= target_next;
      flush_reg <= flush_next;
      wreg_we_reg <= wreg_we_next;
      wreg_data_reg <= wreg_data_next;
      file_we_reg <= file_we_next;
      file_addr_reg <= file_addr_next;
      file_data_reg <= file_data_next;
      zero_we_reg <= zero_we_next;
      zero_flag_reg <= zero_flag_next;
    end
  end

  // every output is a bare flop, so the core sees no decode glitches
  assign pc_load_out = pc_load_reg;
  assign program_counter_out = target_reg;
  assign flush_out = flush_reg;
  assign wreg_we_out = wreg_we_reg;
  assign wreg_data_out = wreg_data_reg;
  assign file_we_out = file_we_reg;
  assign file_addr_out = file_addr_reg;
  assign file_data_out = file_data_reg;
  assign zero_we_out = zero_we_reg;
  assign zero_flag_out = zero_flag_reg;
  // busy is the slot state itself: high while the next valid word will be dropped
  assign busy_out = state_reg;
endmodule

//--- tb/ibe_exec_sva.sv
/* checker for ibe_exec: jump target, step results, skip flush and dropped slots.
   assumes one clock, sync active-low reset and outputs one cycle after the take. */
`timescale 1ns/1ps
`include "ibe_consts.vh"
module ibe_exec_sva #(parameter DATA_W = 8) (
  input wire logic clk_sys_in, rstn_in, insn_valid_in, pc_load_out, flush_out,
  input wire logic wreg_we_out, file_we_out, zero_we_out, zero_flag_out, busy_out,
  input wire logic [`IBE_INSN_W-1:0] insn_in,
  input wire logic [DATA_W-1:0] file_data_in, pc_page_latch_in, wreg_data_out, file_data_out,
  input wire logic [`IBE_PC_W-1:0] program_counter_out,
  input wire logic [`IBE_FADDR_W-1:0] file_addr_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  wire tk = insn_valid_in && !busy_out;
  // last cycle's operand and low word: the reference for results shown one edge later
  logic [DATA_W-1:0] data_q;
  logic [7:0] low_q;
  always @(posedge clk_sys_in) begin
    data_q <= file_data_in;
    low_q <= insn_in[7:0];
  end
  wire [DATA_W-1:0] inc_q = DATA_W'(data_q + 1);
  wire [DATA_W-1:0] dec_q = DATA_W'(data_q - 1);
  sequence s_jump;
    tk && insn_in[13:11] == `IBE_OP_JUMP;
  endsequence
  property p_jump;
    s_jump |=> pc_load_out && flush_out
      && program_counter_out == {$past(pc_page_latch_in[4:3]), $past(insn_in[10:0])};
  endproperty
  // skip forms never touch the zero flag, so zw doubles as the skip selector
  property p_step(opc, expv, zw);
    tk && insn_in[13:8] == opc |=> zero_we_out == zw
      && (zw ? zero_flag_out == (expv == 0) && !flush_out : flush_out == (expv == 0))
      && (low_q[7] ? file_we_out && !wreg_we_out && file_data_out == expv
      && file_addr_out == low_q[6:0] : wreg_we_out && !file_we_out && wreg_data_out == expv);
  endproperty
  a_jump_target: assert property (p_jump)
    else $error("jump target or flush wrong");
  a_jump_noflag: assert property (s_jump |=> !zero_we_out && !wreg_we_out && !file_we_out)
    else $error("jump wrote data or flag");
  a_dec_result: assert property (p_step(`IBE_OP_DEC_FILE, dec_q, 1'h1))
    else $error("decrement result wrong");
  a_inc_result: assert property (p_step(`IBE_OP_INC_FILE, inc_q, 1'h1))
    else $error("increment result wrong");
  a_decsz_skip: assert property (p_step(`IBE_OP_DEC_SKIP, dec_q, 1'h0))
    else $error("decrement skip wrong");
  a_incsz_skip: assert property (p_step(`IBE_OP_INC_SKIP, inc_q, 1'h0))
    else $error("increment skip wrong");
  a_busy_drop: assert property (busy_out && insn_valid_in |=> !busy_out && !pc_load_out
    && !flush_out && !wreg_we_out && !file_we_out && !zero_we_out)
    else $error("dropped slot not a no-op");
  a_flush_busy: assert property (flush_out |-> busy_out)
    else $error("flush without busy");
endmodule
bind ibe_exec ibe_exec_sva #(.DATA_W(DATA_W)) u_sva (.*);

//--- tb/ibe_exec_tb.sv
/* self-checking bench for ibe_exec: random instruction stream with wrap data.
   assumes registered one-cycle outputs and one dropped slot after jump or skip. */
`timescale 1ns/1ps
`include "ibe_consts.vh"
module ibe_exec_tb;
  logic clk_sys_in = 0, rstn_in = 0, insn_valid_in = 0, drop = 0;
  logic [13:0] insn_in = 0;
  logic [7:0] file_data_in = 0, pc_page_latch_in = 0;
  wire pc_load_out, flush_out, wreg_we_out, file_we_out, zero_we_out, zero_flag_out, busy_out;
  wire [12:0] program_counter_out;
  wire [7:0] wreg_data_out, file_data_out;
  wire [6:0] file_addr_out;
  logic [21:0] exp_q[$];
  logic [31:0] rng = 71865;
  logic [5:0] ops[6] = '{6'h03, 6'h0A, 6'h0B, 6'h0F, 6'h28, 6'h3F};
  int error_cnt = 0, tests_run = 0;
  ibe_exec dut (.*);
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // an empty queue yields all ones, so any unexpected output mismatches
  always @(negedge clk_sys_in) if (pc_load_out | wreg_we_out | file_we_out) begin
    check({pc_load_out, flush_out, wreg_we_out, file_we_out, zero_we_out,
      zero_flag_out & zero_we_out, pc_load_out ? {3'h0, program_counter_out} : {1'b0,
      file_addr_out & {7{file_we_out}}, file_we_out ? file_data_out : wreg_data_out}},
      exp_q.size() ? exp_q.pop_front() : '1);
  end
  task automatic slot(input logic [31:0] r);
    logic [13:0] ins;
    logic [7:0] dat, v;
    logic sk, fl;
    ins = {ops[r[2:0] % 6], r[15:8]};
    if (ins[13:11] == 3'h5) ins[10:8] = r[18:16];
    dat = r[20:19] == 0 ? 8'hFF : r[20:19] == 1 ? 8'h01 : r[20:19] == 2 ? 8'h00 : r[28:21];
    @(posedge clk_sys_in);
    insn_valid_in <= r[31:29] != 0;
    insn_in <= ins;
    file_data_in <= dat;
    pc_page_latch_in <= r[7:0];
    if (r[31:29] == 0) return;
    if (drop) begin
      drop = 0;
    end else if (ins[13:11] == 3'h5) begin
      exp_q.push_back({6'h30, 3'h0, r[4:3], ins[10:0]});
      drop = 1;
    end else if (ins[13:8] inside {6'h03, 6'h0A, 6'h0B, 6'h0F}) begin
      v = (ins[13:8] == 6'h0A || ins[13:8] == 6'h0F) ? dat + 8'h01 : dat - 8'h01;
      sk = ins[13:8] == 6'h0B || ins[13:8] == 6'h0F;
      fl = sk && v == 0;
      exp_q.push_back({1'b0, fl, !ins[7], ins[7], !sk, !sk && v == 0, 1'b0,
        ins[7] ? ins[6:0] : 7'h0, v});
      drop = fl;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1;
    for (int i = 0; i < 3000; i++) begin
      rng = xs(rng);
      slot(rng);
    end
    @(posedge clk_sys_in) insn_valid_in <= 0;
    repeat (3) @(posedge clk_sys_in);
    check(exp_q.size(), 0);
    $display("test random_stream done");
    end_of_test;
  end
  initial begin
    #(5 * 4000);
    error_cnt++;
    end_of_test;
  end
endmodule
